// ---- src/bhu_regs.sv ----
// Upper header register bank of a two-port bridge with AXI4-Lite access
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module bhu_regs (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // AXI4-Lite write address channel
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    // AXI4-Lite write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    // AXI4-Lite write response channel
    output      logic [1:0]        s_axi_bresp,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address channel
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    // AXI4-Lite read data channel
    output      logic [31:0]       s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Addresses under test from the forwarding logic (same clock)
    input  wire logic [63:0]       pf_addr_i,
    input  wire logic [31:0]       io_addr_i,
    // Secondary side pins (asynchronous)
    input  wire logic              sec_addr_perr_i,
    input  wire logic              sec_data_perr_i,
    input  wire logic              secondary_system_error_n_i,
    // Forwarding decisions and events
    output      bhu_pkg::bhu_evt_t evt_o,
    output      bhu_pkg::bhu_cfg_t cfg_o
);

    // Every group of state below has a _next partner computed in one of five
    // combinational processes and captured by the single clocked process
    // Register bank state
    bhu_pkg::bhu_cfg_t cfg_reg;        // Software settings
    bhu_pkg::bhu_cfg_t cfg_next;       // Settings after this cycle

    // Write channel state
    // A half that arrives alone is parked here until its partner comes
    logic              aw_have_reg;    // Write address held
    logic              aw_have_next;
    logic [7:0]        aw_addr_reg;    // Held write address
    logic [7:0]        aw_addr_next;
    logic              w_have_reg;     // Write data held
    logic              w_have_next;
    logic [31:0]       w_data_reg;     // Held write data
    logic [31:0]       w_data_next;
    logic [3:0]        w_strb_reg;     // Held byte enables
    logic [3:0]        w_strb_next;
    logic              bvalid_reg;     // Write response pending
    logic              bvalid_next;
    logic [1:0]        bresp_reg;      // Write response code
    logic [1:0]        bresp_next;

    // Read channel state
    // Read data is captured at the address handshake and then held
    logic              rvalid_reg;     // Read data pending
    logic              rvalid_next;
    logic [31:0]       rdata_reg;      // Read data
    logic [31:0]       rdata_next;
    logic [1:0]        rresp_reg;      // Read response code
    logic [1:0]        rresp_next;

    // Pin synchronisers, stage one feeds stage two only
    // Bit 0 address parity, bit 1 data parity, bit 2 system error (low)
    // Both stages reset to the idle level so no false event follows reset
    logic [2:0]        sync1_reg;
    logic [2:0]        sync1_next;
    logic [2:0]        sync2_reg;
    logic [2:0]        sync2_next;

    // Decision outputs
    bhu_pkg::bhu_evt_t evt_reg;
    bhu_pkg::bhu_evt_t evt_next;

    // Write path helpers
    logic              aw_take;        // Address handshake now
    logic              w_take;         // Data handshake now
    logic              do_write;       // Both halves present
    logic [7:0]        wr_addr;        // Effective write address
    logic [31:0]       wr_data;        // Effective write data
    logic [3:0]        wr_strb;        // Effective byte enables
    logic              wr_hit;         // Write address mapped

    // Read path helpers
    logic              ar_take;        // Read handshake now
    logic [31:0]       rd_word;        // Word at the read address
    logic              rd_hit;         // Read address mapped

    // Combined 64-bit prefetch bounds
    logic [63:0]       pf_lo;
    logic [63:0]       pf_hi;

    // Merge one word under byte enables
    // Lanes whose strobe is low keep the value the register reads now
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Pack the live settings into bus words
    // Fixed codes and read-only bytes are built here, never stored
    // Unmapped offsets read as zero
    function automatic logic [31:0] word_of(input bhu_pkg::bhu_cfg_t c,
                                            input logic [7:0]        a);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            bhu_pkg::OFS_PF_LOW: begin
                w[bhu_pkg::PF_BASE_LSB +: 12] = c.pf_base12;
                w[3:0] = bhu_pkg::PF_ADDR64;
                w[bhu_pkg::PF_LIM_LSB +: 12] = c.pf_lim12;
                w[bhu_pkg::PF_LIM_CODE +: 4] = bhu_pkg::PF_ADDR64;
            end
            bhu_pkg::OFS_PF_BASE_HI: w = c.pf_base_hi;
            bhu_pkg::OFS_PF_LIM_HI:  w = c.pf_lim_hi;
            bhu_pkg::OFS_IO_HI: begin
                w[15:0] = c.io_base_hi;
                w[bhu_pkg::IO_LIM_LSB +: 16] = c.io_lim_hi;
            end
            bhu_pkg::OFS_CAP: w[7:0] = bhu_pkg::CAP_PTR_VAL;
            bhu_pkg::OFS_IRQ_CTL: begin
                w[7:0] = c.irq_line;
                w[bhu_pkg::IRQ_PIN_LSB +: 8] = bhu_pkg::IRQ_PIN_VAL;
                w[bhu_pkg::PERR_RESP_BIT] = c.perr_resp;
                w[bhu_pkg::SERR_EN_BIT] = c.serr_en;
            end
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    // Offsets that answer OKAY
    // Everything else gets SLVERR and leaves the settings untouched
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            bhu_pkg::OFS_PF_LOW, bhu_pkg::OFS_PF_BASE_HI,
            bhu_pkg::OFS_PF_LIM_HI, bhu_pkg::OFS_IO_HI,
            bhu_pkg::OFS_CAP, bhu_pkg::OFS_IRQ_CTL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Handshake outputs straight from state
    // Both channels stall while a response waits, so one write is in flight
    assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_have_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign evt_o         = evt_reg;
    assign cfg_o         = cfg_reg;

    // Write path: address and data may come in either order
    // Readies stay low while a half is held, so each channel moves one item
    // A new write is taken only after the response has been accepted
    always_comb begin
        aw_take      = s_axi_awvalid & s_axi_awready;
        w_take       = s_axi_wvalid & s_axi_wready;
        wr_addr      = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
        wr_data      = w_have_reg ? w_data_reg : s_axi_wdata;
        wr_strb      = w_have_reg ? w_strb_reg : s_axi_wstrb;
        do_write     = (aw_have_reg | aw_take) & (w_have_reg | w_take);
        wr_hit       = mapped({wr_addr[7:2], 2'b00});
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next  = w_have_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        // Hold a half that arrives alone
        if (aw_take) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (w_take) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        // Both halves present: commit and answer next cycle
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit ? bhu_pkg::RESP_OKAY : bhu_pkg::RESP_SLVERR;
        end else if (bvalid_reg & s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // Register updates from committed writes
    // Read-modify-write: the current word is merged with the new lanes so
    // byte writes to one field leave its neighbours as they were
    always_comb begin
        logic [31:0] w;
        w        = 32'h0;
        cfg_next = cfg_reg;
        if (do_write & wr_hit) begin
            w = merge(word_of(cfg_reg, {wr_addr[7:2], 2'b00}), wr_data, wr_strb);
            case ({wr_addr[7:2], 2'b00})
                bhu_pkg::OFS_PF_LOW: begin
                    // Low nibbles are fixed codes and never stored
                    cfg_next.pf_base12 = w[bhu_pkg::PF_BASE_LSB +: 12];
                    cfg_next.pf_lim12  = w[bhu_pkg::PF_LIM_LSB +: 12];
                end
                bhu_pkg::OFS_PF_BASE_HI: cfg_next.pf_base_hi = w;
                bhu_pkg::OFS_PF_LIM_HI:  cfg_next.pf_lim_hi  = w;
                bhu_pkg::OFS_IO_HI: begin
                    cfg_next.io_base_hi = w[15:0];
                    cfg_next.io_lim_hi  = w[bhu_pkg::IO_LIM_LSB +: 16];
                end
                bhu_pkg::OFS_IRQ_CTL: begin
                    // Any value is kept, FFh marks no pin in use
                    cfg_next.irq_line  = w[7:0];
                    // Pin byte has no storage, so its lane is dropped
                    cfg_next.perr_resp = w[bhu_pkg::PERR_RESP_BIT];
                    cfg_next.serr_en   = w[bhu_pkg::SERR_EN_BIT];
                end
                default: cfg_next = cfg_reg;
            endcase
        end
    end

    // Read path: data registered one cycle after the address is taken
    // Reads see the settings before any write committed in the same cycle
    // Unmapped reads return zero with SLVERR
    always_comb begin
        ar_take     = s_axi_arvalid & s_axi_arready;
        rd_hit      = mapped({s_axi_araddr[7:2], 2'b00});
        rd_word     = word_of(cfg_reg, {s_axi_araddr[7:2], 2'b00});
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (ar_take) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_word;
            rresp_next  = rd_hit ? bhu_pkg::RESP_OKAY : bhu_pkg::RESP_SLVERR;
        end else if (rvalid_reg & s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // Synchroniser stages for the secondary pins
    // The pins are asynchronous; only stage two feeds the decision logic
    always_comb begin
        sync1_next = {secondary_system_error_n_i, sec_data_perr_i, sec_addr_perr_i};
        sync2_next = sync1_reg;
    end

    // Forwarding decisions, one cycle behind their inputs
    // Decisions are registered so the forwarding logic sees clean levels
    // Pin events reach evt_o three edges after the pin changes
    always_comb begin
        pf_lo    = {cfg_reg.pf_base_hi, cfg_reg.pf_base12, bhu_pkg::PF_LOW_ZERO};
        pf_hi    = {cfg_reg.pf_lim_hi, cfg_reg.pf_lim12, bhu_pkg::PF_LOW_ONES};
        evt_next = bhu_pkg::EVT_RST;
        // Both bounds included
        evt_next.pf_hit = (pf_addr_i >= pf_lo) && (pf_addr_i <= pf_hi);
        // Only the upper halves live here; low halves are checked elsewhere
        evt_next.io_hit = (io_addr_i[31:16] >= cfg_reg.io_base_hi) &&
                          (io_addr_i[31:16] <= cfg_reg.io_lim_hi);
        // Parity errors dropped unless response enabled
        evt_next.perr_report = cfg_reg.perr_resp & (sync2_reg[0] | sync2_reg[1]);
        // Active-low system error passes only when enabled
        evt_next.serr_fwd = cfg_reg.serr_en & ~sync2_reg[2];
    end

    // All state registers, synchronous reset
    // Reset returns every setting to zero and drops any pending answer
    // A transfer cut by reset is simply lost; the master must retry
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_reg     <= bhu_pkg::CFG_RST;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_have_reg  <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= bhu_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= bhu_pkg::RESP_OKAY;
            sync1_reg   <= 3'h4;
            sync2_reg   <= 3'h4;
            evt_reg     <= bhu_pkg::EVT_RST;
        end else begin
            cfg_reg     <= cfg_next;
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg  <= w_have_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            sync1_reg   <= sync1_next;
            sync2_reg   <= sync2_next;
            evt_reg     <= evt_next;
        end
    end

endmodule // bhu_regs

// ---- src/bhu_pkg.sv ----
// Constants, field layouts and carriers for the bridge header upper register bank
package bhu_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PF_LOW     = 8'h24;
    localparam logic [7:0] OFS_PF_BASE_HI = 8'h28;
    localparam logic [7:0] OFS_PF_LIM_HI  = 8'h2c;
    localparam logic [7:0] OFS_IO_HI      = 8'h30;
    localparam logic [7:0] OFS_CAP        = 8'h34;
    localparam logic [7:0] OFS_IRQ_CTL    = 8'h3c;
    // Field positions
    localparam int unsigned PF_BASE_LSB   = 4;
    localparam int unsigned PF_LIM_LSB    = 20;
    localparam int unsigned PF_LIM_CODE   = 16;
    localparam int unsigned IO_LIM_LSB    = 16;
    localparam int unsigned IRQ_PIN_LSB   = 8;
    localparam int unsigned PERR_RESP_BIT = 16;
    localparam int unsigned SERR_EN_BIT   = 17;
    // Fixed read values and reset values
    localparam logic [7:0]  CAP_PTR_VAL   = 8'hdc;
    localparam logic [3:0]  PF_ADDR64     = 4'h1;
    localparam logic [7:0]  IRQ_PIN_VAL   = 8'h00;
    localparam logic [7:0]  IRQ_LINE_RST  = 8'h00;
    localparam logic [19:0] PF_LOW_ZERO   = 20'h00000;
    localparam logic [19:0] PF_LOW_ONES   = 20'hfffff;
    // AXI response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Software-visible configuration state
    typedef struct packed {
        logic [31:0] pf_base_hi;
        logic [31:0] pf_lim_hi;
        logic [11:0] pf_base12;
        logic [11:0] pf_lim12;
        logic [15:0] io_base_hi;
        logic [15:0] io_lim_hi;
        logic [7:0]  irq_line;
        logic        perr_resp;
        logic        serr_en;
    } bhu_cfg_t;

    localparam bhu_cfg_t CFG_RST = '{pf_base_hi: 32'h0, pf_lim_hi: 32'h0,
        pf_base12: 12'h0, pf_lim12: 12'h0, io_base_hi: 16'h0, io_lim_hi: 16'h0,
        irq_line: IRQ_LINE_RST, perr_resp: 1'b0, serr_en: 1'b0};

    // Decisions and events handed to the forwarding logic
    typedef struct packed {
        logic pf_hit;
        logic io_hit;
        logic perr_report;
        logic serr_fwd;
    } bhu_evt_t;

    localparam bhu_evt_t EVT_RST = '{pf_hit: 1'b0, io_hit: 1'b0,
        perr_report: 1'b0, serr_fwd: 1'b0};
endpackage

// ---- sim/bhu_regs_sva.sv ----
// Concurrent checks on the ports of the bridge header upper register bank
`timescale 1ns/10ps
module bhu_regs_sva (
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    // Register bus
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [7:0]        s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Forwarding side
    input wire logic [63:0]       pf_addr_i,
    input wire logic [31:0]       io_addr_i,
    input wire bhu_pkg::bhu_evt_t evt_o,
    input wire bhu_pkg::bhu_cfg_t cfg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Window bounds rebuilt from the live settings
    logic [63:0] pf_lo;
    logic [63:0] pf_hi;
    logic        pf_in;
    logic        io_in;
    assign pf_lo = {cfg_o.pf_base_hi, cfg_o.pf_base12, 20'h00000};
    assign pf_hi = {cfg_o.pf_lim_hi, cfg_o.pf_lim12, 20'hfffff};
    assign pf_in = (pf_addr_i >= pf_lo) && (pf_addr_i <= pf_hi);
    assign io_in = (io_addr_i[31:16] >= cfg_o.io_base_hi) && (io_addr_i[31:16] <= cfg_o.io_lim_hi);
    // Handshake steps
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Gates held closed long enough to flush the sync stages
    sequence s_perr_off;
        (!cfg_o.perr_resp) [*4];
    endsequence
    sequence s_serr_off;
        (!cfg_o.serr_en) [*4];
    endsequence
    a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_cap_read: assert property (s_rd_take ##0 (s_axi_araddr == bhu_pkg::OFS_CAP) |=> s_axi_rdata == 32'h000000dc)
        else $error("capability pointer wrong");
    a_pin_read: assert property (s_rd_take ##0 (s_axi_araddr == bhu_pkg::OFS_IRQ_CTL) |=> s_axi_rdata[15:8] == 8'h00)
        else $error("interrupt pin byte not zero");
    a_pf_window: assert property (!$past(sys_rst_i) |-> evt_o.pf_hit == $past(pf_in))
        else $error("prefetch window decision wrong");
    a_io_window: assert property (!$past(sys_rst_i) |-> evt_o.io_hit == $past(io_in))
        else $error("io window decision wrong");
    a_perr_gate: assert property (s_perr_off |-> !evt_o.perr_report)
        else $error("parity error reported while ignored");
    a_serr_gate: assert property (s_serr_off |-> !evt_o.serr_fwd)
        else $error("system error forwarded while blocked");
endmodule // bhu_regs_sva

bind bhu_regs bhu_regs_sva bhu_regs_sva_inst (.clk_i, .sys_rst_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pf_addr_i,
    .io_addr_i, .evt_o, .cfg_o);

// ---- sim/bhu_regs_tb_top.sv ----
// Self-checking testbench for the bridge header upper register bank
`timescale 1ns/10ps
module bhu_regs_tb_top;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] e;
        logic [1:0]  r;
    } bhu_row_t;
    // Strobe zero means read only; reset rows come first
    bhu_row_t rows[15] = '{
        '{8'h28, 32'h0, 4'h0, 32'h0, 2'h0}, '{8'h2c, 32'h0, 4'h0, 32'h0, 2'h0},
        '{8'h30, 32'h0, 4'h0, 32'h0, 2'h0}, '{8'h24, 32'h0, 4'h0, 32'h00010001, 2'h0},
        '{8'h34, 32'h0, 4'h0, 32'h000000dc, 2'h0}, '{8'h3c, 32'h0, 4'h0, 32'h0, 2'h0},
        '{8'h28, 32'ha5a51234, 4'hf, 32'ha5a51234, 2'h0},
        '{8'h2c, 32'hffff0000, 4'hf, 32'hffff0000, 2'h0},
        '{8'h2c, 32'h11223344, 4'h5, 32'hff220044, 2'h0},
        '{8'h30, 32'h1234abcd, 4'hf, 32'h1234abcd, 2'h0},
        '{8'h24, 32'hffffffff, 4'hf, 32'hfff1fff1, 2'h0},
        '{8'h34, 32'hffffffff, 4'hf, 32'h000000dc, 2'h0},
        '{8'h3c, 32'h0000ffff, 4'hf, 32'h000000ff, 2'h0},
        '{8'h3c, 32'h00035a11, 4'hf, 32'h00030011, 2'h0},
        '{8'h40, 32'h00000001, 4'hf, 32'h0, 2'h2}};
    // Design inputs, all given a value at time zero
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [63:0] pf_addr_i = 64'h0;
    logic [31:0] io_addr_i = 32'h0;
    logic        sec_addr_perr_i = 1'b0;
    logic        sec_data_perr_i = 1'b0;
    logic        secondary_system_error_n_i = 1'b1;
    // Design outputs
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    bhu_pkg::bhu_evt_t evt_o;
    bhu_pkg::bhu_cfg_t cfg_o;
    int          mismatches = 0;
    int          checks_done = 0;

    bhu_regs bhu_regs_inst (.clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pf_addr_i, .io_addr_i, .sec_addr_perr_i, .sec_data_perr_i,
        .secondary_system_error_n_i, .evt_o, .cfg_o);

    task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_flag(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task final_report;
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where readies are settled for the next rise
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic ta = 1'b0;
        logic tw = 1'b0;
        logic b = 1'b0;
        logic [1:0] r = 2'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge clk_i);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge clk_i);
        chk_flag("bvalid", 1'b1, b);
        chk_word("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic v = 1'b0;
        logic t = 1'b0;
        logic [31:0] d = 32'h0;
        logic [1:0] r = 2'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        // Address is released only after the edge that took it
        while (!v) begin
            @(negedge clk_i);
            t = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge clk_i);
        chk_flag("rvalid", 1'b1, v);
        chk_word("rdata", e, d);
        chk_word("rresp", {30'h0, er}, {30'h0, r});
    endtask
    task probe(input logic [63:0] p, input logic [31:0] i, input logic ep, input logic ei);
        pf_addr_i <= p;
        io_addr_i <= i;
        @(posedge clk_i);
        @(negedge clk_i);
        chk_flag("pf_hit", ep, evt_o.pf_hit);
        chk_flag("io_hit", ei, evt_o.io_hit);
        @(posedge clk_i);
    endtask
    // Lets the two-flop synchroniser and output stage settle
    task ev_chk(input logic ep, input logic es);
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        chk_flag("perr_report", ep, evt_o.perr_report);
        chk_flag("serr_fwd", es, evt_o.serr_fwd);
        @(posedge clk_i);
    endtask

    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[k]) begin
            if (rows[k].s !== 4'h0) axi_wr(rows[k].a, rows[k].d, rows[k].s, rows[k].r);
            reg_chk(rows[k].a, rows[k].e, rows[k].r);
        end
        // Window 1_1000_0000 to 1_200f_ffff and io 0010 to 0020
        axi_wr(8'h28, 32'h1, 4'hf, 2'h0);
        axi_wr(8'h2c, 32'h1, 4'hf, 2'h0);
        axi_wr(8'h24, 32'h20001000, 4'hf, 2'h0);
        axi_wr(8'h30, 32'h00200010, 4'hf, 2'h0);
        probe(64'h0000000110000000, 32'h00100000, 1'b1, 1'b1);
        probe(64'h000000010fffffff, 32'h000fffff, 1'b0, 1'b0);
        probe(64'h00000001200fffff, 32'h0020ffff, 1'b1, 1'b1);
        probe(64'h0000000120100000, 32'h00210000, 1'b0, 1'b0);
        probe(64'h0000000215000000, 32'h00180000, 1'b0, 1'b1);
        // Error inputs against both gates
        axi_wr(8'h3c, 32'h000000ff, 4'hf, 2'h0);
        sec_addr_perr_i <= 1'b1;
        secondary_system_error_n_i <= 1'b0;
        ev_chk(1'b0, 1'b0);
        axi_wr(8'h3c, 32'h000100ff, 4'hf, 2'h0);
        ev_chk(1'b1, 1'b0);
        sec_addr_perr_i <= 1'b0;
        sec_data_perr_i <= 1'b1;
        ev_chk(1'b1, 1'b0);
        axi_wr(8'h3c, 32'h000300ff, 4'hf, 2'h0);
        ev_chk(1'b1, 1'b1);
        sec_data_perr_i <= 1'b0;
        secondary_system_error_n_i <= 1'b1;
        ev_chk(1'b0, 1'b0);
        // Reset in mid-run must clear what software wrote
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        reg_chk(8'h3c, 32'h0, 2'h0);
        reg_chk(8'h28, 32'h0, 2'h0);
        final_report;
    end
endmodule // bhu_regs_tb_top
